//--- hdl/pvp_pkg.sv
// Contract
// - Reset clears every register except both timers' latches, counters and the shifter.
// - After reset all port and strobe lines are inputs and interrupts are off.
// - Every register transfer is timed by the phase-two clock input.
// - With read-write low in a selected cycle the byte is stored in that register.
// - With read-write high and selected, the addressed register is driven onto the bus.
// - Data lines float when unselected and are inputs during write cycles.
// - Access only while high select is high and low select is low together.
// - Four index inputs, highest most significant, choose one of sixteen registers.
// - Interrupt request pulls low while any flag is set with its enable at one.
// - Interrupt request is open-drain: it only pulls low or floats.
// - Index 1 writes port A output, reads port A input; index 0 likewise port B.
// - Index 2 holds port B direction, index 3 port A direction, both read-write.
// - Timer one: 4 latch-low write or counter-low read, 5 counter-high, 6, 7 latches.
// - Timer two: 8 latch-low write or counter-low read, 9 counter-high.
// - Shifter at 10, auxiliary at 11, line control 12, flags 13, enables 14.
// - Index 15 reaches port A like index 1 but without handshake activity.
// - Direction bit zero makes the pin an input, one makes it an output.
// - Port B read returns the output latch bit for pins set as outputs.
package pvp_pkg;

  // Register indices as seen on the four index inputs.
  localparam logic [3:0] REG_PORT_B       = 4'h0;
  localparam logic [3:0] REG_PORT_A       = 4'h1;
  localparam logic [3:0] REG_DIR_B        = 4'h2;
  localparam logic [3:0] REG_DIR_A        = 4'h3;
  localparam logic [3:0] REG_T1_COUNT_LOW = 4'h4;
  localparam logic [3:0] REG_T1_COUNT_HI  = 4'h5;
  localparam logic [3:0] REG_T1_LATCH_LOW = 4'h6;
  localparam logic [3:0] REG_T1_LATCH_HI  = 4'h7;
  localparam logic [3:0] REG_T2_COUNT_LOW = 4'h8;
  localparam logic [3:0] REG_T2_COUNT_HI  = 4'h9;
  localparam logic [3:0] REG_SHIFTER      = 4'ha;
  localparam logic [3:0] REG_AUX_CONTROL  = 4'hb;
  localparam logic [3:0] REG_LINE_CONTROL = 4'hc;
  localparam logic [3:0] REG_FLAGS        = 4'hd;
  localparam logic [3:0] REG_ENABLES      = 4'he;
  localparam logic [3:0] REG_PORT_A_QUIET = 4'hf;

  // Reset value of every cleared register.
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // Slots of the byte store that survives reset.
  localparam int KEEP_T1_LATCH_LOW = 0;
  localparam int KEEP_T1_LATCH_HI  = 1;
  localparam int KEEP_T1_COUNT_LOW = 2;
  localparam int KEEP_T1_COUNT_HI  = 3;
  localparam int KEEP_T2_LATCH_LOW = 4;
  localparam int KEEP_T2_COUNT_LOW = 5;
  localparam int KEEP_T2_COUNT_HI  = 6;
  localparam int KEEP_SHIFTER      = 7;
  localparam int KEEP_SLOTS        = 8;

  // Field positions in flags, enables and line control.
  localparam int FLAG_BITS        = 7;
  localparam int FLAG_STROBE_A    = 1;
  localparam int FLAG_ANY         = 7;
  localparam int ENABLE_SET       = 7;
  localparam int LINE_A_RISING    = 0;
  localparam int LINE_A_IO_OUTPUT = 3;

  // Depth of the pin synchroniser.
  localparam int SYNC_STAGES = 2;

  // Processor bus pins.
  typedef struct packed {
    logic       phi2;
    logic       selectHigh;
    logic       selectLowN;
    logic       readWrite;
    logic [3:0] registerIndex;
    logic [7:0] hostData;
  } pvp_bus_type;

  // Everything that crosses in from the pins.
  typedef struct packed {
    pvp_bus_type bus;
    logic [7:0]  portAPins;
    logic [7:0]  portBPins;
    logic        portAStrobeIn;
  } pvp_pins_type;

endpackage

//--- hdl/pvp_sync.sv
`timescale 1ns/10ps
// Two-stage synchroniser for a bundle of pin levels.
module pvp_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input  wire logic             core_clk,
  input  wire logic             reset_n,
  // Levels.
  input  wire logic [WIDTH-1:0] asyncIn,
  output      logic [WIDTH-1:0] syncOut
);

  logic [pvp_pkg::SYNC_STAGES-1:0][WIDTH-1:0] stageReg;

  // The first stage is read only by the second one, so metastability stays contained.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      stageReg <= '0;
    end else begin
      stageReg <= {stageReg[pvp_pkg::SYNC_STAGES-2:0], asyncIn};
    end
  end

  assign syncOut = stageReg[pvp_pkg::SYNC_STAGES-1];

endmodule // pvp_sync

//--- hdl/pvp_host_port.sv
`timescale 1ns/10ps
module pvp_host_port (
  // Clock and reset.
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  // Processor bus.
  input  wire logic       phi2,
  input  wire logic       select_high,
  input  wire logic       select_low_n,
  input  wire logic       readWrite,
  input  wire logic [3:0] register_index,
  input  wire logic [7:0] hostDataIn,
  output      logic [7:0] hostDataOut,
  output      logic       hostDataOe,
  // Open-drain interrupt request.
  output      logic       irqOut_n,
  output      logic       irqOe,
  // Port A pins.
  input  wire logic [7:0] portAIn,
  output      logic [7:0] portAOut,
  output      logic [7:0] portAOe,
  // Port B pins.
  input  wire logic [7:0] portBIn,
  output      logic [7:0] portBOut,
  output      logic [7:0] portBOe,
  // Port A strobe lines.
  input  wire logic       port_a_strobe_in,
  output      logic       port_a_strobe_io,
  output      logic       portAStrobeIoOe
);

  ////////////////////////////////////////////////////////////////////////////
  // State.

  typedef struct packed {
    logic [7:0]                 portAOutput;
    logic [7:0]                 portADir;
    logic [7:0]                 portBOutput;
    logic [7:0]                 portBDir;
    logic [7:0]                 auxControl;
    logic [7:0]                 lineControl;
    logic [pvp_pkg::FLAG_BITS-1:0] flags;
    logic [pvp_pkg::FLAG_BITS-1:0] enables;
    logic                       phi2Prev;
    logic                       strobePrev;
    logic [7:0]                 dataOut;
    logic                       dataOe;
    logic                       irqActive;
    logic                       strobeIoPulse;
  } pvp_ctl_type;

  typedef struct packed {
    pvp_ctl_type                                ctl;
    logic [pvp_pkg::KEEP_SLOTS-1:0][7:0]        keep;
  } pvp_state_type;

  pvp_state_type         stateReg;
  pvp_state_type         stateNext;
  pvp_pkg::pvp_pins_type pinsRaw;
  pvp_pkg::pvp_pins_type pins;
  logic                  selected;
  logic                  fallEdge;
  logic                  writeNow;
  logic                  readNow;
  logic                  strobeEdge;
  logic [7:0]            portBRead;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation.

  // Every pin input crosses two flops before any decode looks at it.
  assign pinsRaw.bus.phi2          = phi2;
  assign pinsRaw.bus.selectHigh    = select_high;
  assign pinsRaw.bus.selectLowN    = select_low_n;
  assign pinsRaw.bus.readWrite     = readWrite;
  assign pinsRaw.bus.registerIndex = register_index;
  assign pinsRaw.bus.hostData      = hostDataIn;
  assign pinsRaw.portAPins         = portAIn;
  assign pinsRaw.portBPins         = portBIn;
  assign pinsRaw.portAStrobeIn     = port_a_strobe_in;

  pvp_sync #(
    .WIDTH($bits(pvp_pkg::pvp_pins_type))
  ) pinSync (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .asyncIn  (pinsRaw),
    .syncOut  (pins)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode.

  // Both selects must agree before anything is accessed.
  assign selected = pins.bus.selectHigh && !pins.bus.selectLowN;
  // Transfers happen only on the phase-two falling edge.
  assign fallEdge = stateReg.ctl.phi2Prev && !pins.bus.phi2;
  assign writeNow = fallEdge && selected && !pins.bus.readWrite;
  assign readNow  = fallEdge && selected && pins.bus.readWrite;

  // The strobe edge polarity comes from line control.
  assign strobeEdge = stateReg.ctl.lineControl[pvp_pkg::LINE_A_RISING] ?
                      (!stateReg.ctl.strobePrev && pins.portAStrobeIn) :
                      (stateReg.ctl.strobePrev && !pins.portAStrobeIn);

  // Output pins show the latch bit, not the loaded pin level.
  assign portBRead = (stateReg.ctl.portBOutput & stateReg.ctl.portBDir) |
                     (pins.portBPins & ~stateReg.ctl.portBDir);

  // Read multiplexer; the index is a plain binary number.
  function automatic logic [7:0] readByte(input logic [3:0] index, input pvp_state_type st,
                                          input logic [7:0] portA, input logic [7:0] portB);
    logic [7:0] value;
    value = pvp_pkg::RESET_BYTE;
    case (index)
      pvp_pkg::REG_PORT_B:       value = portB;
      pvp_pkg::REG_PORT_A:       value = portA;
      pvp_pkg::REG_PORT_A_QUIET: value = portA;
      pvp_pkg::REG_DIR_B:        value = st.ctl.portBDir;
      pvp_pkg::REG_DIR_A:        value = st.ctl.portADir;
      pvp_pkg::REG_T1_COUNT_LOW: value = st.keep[pvp_pkg::KEEP_T1_COUNT_LOW];
      pvp_pkg::REG_T1_COUNT_HI:  value = st.keep[pvp_pkg::KEEP_T1_COUNT_HI];
      pvp_pkg::REG_T1_LATCH_LOW: value = st.keep[pvp_pkg::KEEP_T1_LATCH_LOW];
      pvp_pkg::REG_T1_LATCH_HI:  value = st.keep[pvp_pkg::KEEP_T1_LATCH_HI];
      pvp_pkg::REG_T2_COUNT_LOW: value = st.keep[pvp_pkg::KEEP_T2_COUNT_LOW];
      pvp_pkg::REG_T2_COUNT_HI:  value = st.keep[pvp_pkg::KEEP_T2_COUNT_HI];
      pvp_pkg::REG_SHIFTER:      value = st.keep[pvp_pkg::KEEP_SHIFTER];
      pvp_pkg::REG_AUX_CONTROL:  value = st.ctl.auxControl;
      pvp_pkg::REG_LINE_CONTROL: value = st.ctl.lineControl;
      pvp_pkg::REG_FLAGS:        value = {|(st.ctl.flags & st.ctl.enables), st.ctl.flags};
      pvp_pkg::REG_ENABLES:      value = {1'b1, st.ctl.enables};
      default:                   value = pvp_pkg::RESET_BYTE;
    endcase
    return value;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  // One pass builds the whole next state; writes land at the phase-two falling edge.
  always_comb begin
    logic [pvp_pkg::FLAG_BITS-1:0] flagSet;
    logic [pvp_pkg::FLAG_BITS-1:0] flagClear;
    logic [7:0]                    data;
    stateNext = stateReg;
    flagSet   = '0;
    flagClear = '0;
    data      = pins.bus.hostData;
    stateNext.ctl.phi2Prev   = pins.bus.phi2;
    stateNext.ctl.strobePrev = pins.portAStrobeIn;
    flagSet[pvp_pkg::FLAG_STROBE_A] = strobeEdge;
    // Only the true port A index counts as handshake activity; the quiet alias does not.
    stateNext.ctl.strobeIoPulse = (writeNow || readNow) &&
                                  (pins.bus.registerIndex == pvp_pkg::REG_PORT_A);
    if (stateNext.ctl.strobeIoPulse) begin
      flagClear[pvp_pkg::FLAG_STROBE_A] = 1'b1;
    end
    if (writeNow) begin
      case (pins.bus.registerIndex)
        pvp_pkg::REG_PORT_B: begin
          stateNext.ctl.portBOutput = data;
        end
        pvp_pkg::REG_PORT_A, pvp_pkg::REG_PORT_A_QUIET: begin
          stateNext.ctl.portAOutput = data;
        end
        pvp_pkg::REG_DIR_B: begin
          stateNext.ctl.portBDir = data;
        end
        pvp_pkg::REG_DIR_A: begin
          stateNext.ctl.portADir = data;
        end
        pvp_pkg::REG_T1_COUNT_LOW, pvp_pkg::REG_T1_LATCH_LOW: begin
          stateNext.keep[pvp_pkg::KEEP_T1_LATCH_LOW] = data;
        end
        pvp_pkg::REG_T1_COUNT_HI: begin
          // Loading the high counter also moves the low latch into the counter.
          stateNext.keep[pvp_pkg::KEEP_T1_COUNT_HI]  = data;
          stateNext.keep[pvp_pkg::KEEP_T1_LATCH_HI]  = data;
          stateNext.keep[pvp_pkg::KEEP_T1_COUNT_LOW] = stateReg.keep[pvp_pkg::KEEP_T1_LATCH_LOW];
        end
        pvp_pkg::REG_T1_LATCH_HI: begin
          stateNext.keep[pvp_pkg::KEEP_T1_LATCH_HI] = data;
        end
        pvp_pkg::REG_T2_COUNT_LOW: begin
          stateNext.keep[pvp_pkg::KEEP_T2_LATCH_LOW] = data;
        end
        pvp_pkg::REG_T2_COUNT_HI: begin
          stateNext.keep[pvp_pkg::KEEP_T2_COUNT_HI]  = data;
          stateNext.keep[pvp_pkg::KEEP_T2_COUNT_LOW] = stateReg.keep[pvp_pkg::KEEP_T2_LATCH_LOW];
        end
        pvp_pkg::REG_SHIFTER: begin
          stateNext.keep[pvp_pkg::KEEP_SHIFTER] = data;
        end
        pvp_pkg::REG_AUX_CONTROL: begin
          stateNext.ctl.auxControl = data;
        end
        pvp_pkg::REG_LINE_CONTROL: begin
          stateNext.ctl.lineControl = data;
        end
        pvp_pkg::REG_FLAGS: begin
          // Writing a one clears that flag.
          flagClear = flagClear | data[pvp_pkg::FLAG_BITS-1:0];
        end
        pvp_pkg::REG_ENABLES: begin
          // The top bit chooses whether the written ones set or clear enables.
          if (data[pvp_pkg::ENABLE_SET]) begin
            stateNext.ctl.enables = stateReg.ctl.enables | data[pvp_pkg::FLAG_BITS-1:0];
          end else begin
            stateNext.ctl.enables = stateReg.ctl.enables & ~data[pvp_pkg::FLAG_BITS-1:0];
          end
        end
        default: begin
          stateNext.ctl.auxControl = stateReg.ctl.auxControl;
        end
      endcase
    end
    // A flag event in the clearing cycle still lands, since set is applied last.
    stateNext.ctl.flags = (stateReg.ctl.flags & ~flagClear) | flagSet;
    // The request line pulls while any enabled flag is up.
    stateNext.ctl.irqActive = |(stateNext.ctl.flags & stateNext.ctl.enables);
    // Read data is driven only in a selected read cycle with phase two high.
    stateNext.ctl.dataOe  = pins.bus.phi2 && selected && pins.bus.readWrite;
    stateNext.ctl.dataOut = readByte(pins.bus.registerIndex, stateReg, pins.portAPins, portBRead);
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.

  // Timer and shifter bytes have no reset term, so they ride through a reset untouched.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      stateReg.ctl <= '0;
    end else begin
      stateReg <= stateNext;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  // Direction bits drive the enables directly, so reset leaves every line an input.
  assign portAOut        = stateReg.ctl.portAOutput;
  assign portAOe         = stateReg.ctl.portADir;
  assign portBOut        = stateReg.ctl.portBOutput;
  assign portBOe         = stateReg.ctl.portBDir;
  assign hostDataOut     = stateReg.ctl.dataOut;
  assign hostDataOe      = stateReg.ctl.dataOe;
  assign irqOe           = stateReg.ctl.irqActive;
  assign irqOut_n        = 1'b0;
  assign port_a_strobe_io = stateReg.ctl.strobeIoPulse;
  assign portAStrobeIoOe = stateReg.ctl.lineControl[pvp_pkg::LINE_A_IO_OUTPUT];

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  // Properties watch the synchronised pins, which is the same view the decode acts on.
  property p_select_both;
    @(posedge core_clk) disable iff (!reset_n)
      hostDataOe |-> $past(pins.bus.selectHigh) && !$past(pins.bus.selectLowN);
  endproperty
  a_select_both: assert property (p_select_both) else $error("Data driven while unselected.");

  property p_read_phase;
    @(posedge core_clk) disable iff (!reset_n)
      hostDataOe |-> $past(pins.bus.phi2) && $past(pins.bus.readWrite);
  endproperty
  a_read_phase: assert property (p_read_phase) else $error("Data driven outside a read.");

  property p_float_unselected;
    @(posedge core_clk) disable iff (!reset_n)
      !selected |=> !hostDataOe;
  endproperty
  a_float_unselected: assert property (p_float_unselected) else $error("Bus not floated.");

  property p_write_dir_a;
    @(posedge core_clk) disable iff (!reset_n)
      (writeNow && pins.bus.registerIndex == pvp_pkg::REG_DIR_A) |=>
        portAOe == $past(pins.bus.hostData);
  endproperty
  a_write_dir_a: assert property (p_write_dir_a) else $error("Direction A not stored.");

  property p_dir_only_on_write;
    @(posedge core_clk) disable iff (!reset_n)
      $changed(portBOe) |-> $past(writeNow) && $past(pins.bus.registerIndex) == pvp_pkg::REG_DIR_B;
  endproperty
  a_dir_only_on_write: assert property (p_dir_only_on_write) else $error("Stray write.");

  property p_quiet_alias;
    @(posedge core_clk) disable iff (!reset_n)
      (writeNow && pins.bus.registerIndex == pvp_pkg::REG_PORT_A_QUIET) |=>
        portAOut == $past(pins.bus.hostData) && !port_a_strobe_io;
  endproperty
  a_quiet_alias: assert property (p_quiet_alias) else $error("Quiet alias misbehaves.");

  // Latch and direction come from the cycle the byte was built in, so a write that
  // lands on the same edge is not mistaken for a wrong read.
  property p_port_b_read;
    @(posedge core_clk) disable iff (!reset_n)
      (pins.bus.registerIndex == pvp_pkg::REG_PORT_B) |=>
        ((hostDataOut & $past(portBOe)) == ($past(portBOut) & $past(portBOe)));
  endproperty
  a_port_b_read: assert property (p_port_b_read) else $error("Port B output bits wrong.");

  property p_irq_level;
    @(posedge core_clk) disable iff (!reset_n)
      ##1 irqOe == |($past(stateNext.ctl.flags) & $past(stateNext.ctl.enables));
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("Request level wrong.");

  property p_open_drain;
    @(posedge core_clk) disable iff (!reset_n)
      irqOe |-> irqOut_n == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("Request drives high.");

  property p_after_reset;
    @(posedge core_clk) disable iff (!reset_n)
      $rose(reset_n) |-> portAOe == '0 && portBOe == '0 && !irqOe && !portAStrobeIoOe;
  endproperty
  a_after_reset: assert property (p_after_reset) else $error("Lines not idle after reset.");

  property p_flag_set_wins;
    @(posedge core_clk) disable iff (!reset_n)
      strobeEdge |=> stateReg.ctl.flags[pvp_pkg::FLAG_STROBE_A];
  endproperty
  a_flag_set_wins: assert property (p_flag_set_wins) else $error("Strobe event lost.");

  // A true port A access must pulse the strobe line in the following cycle.
  property p_port_a_pulse;
    @(posedge core_clk) disable iff (!reset_n)
      (fallEdge && selected && pins.bus.registerIndex == pvp_pkg::REG_PORT_A) |=>
        port_a_strobe_io;
  endproperty
  a_port_a_pulse: assert property (p_port_a_pulse) else $error("Port A strobe missing.");

  // Loading the high counter must move the low latch into the low counter.
  property p_timer_one_load;
    @(posedge core_clk) disable iff (!reset_n)
      (writeNow && pins.bus.registerIndex == pvp_pkg::REG_T1_COUNT_HI) |=>
        (stateReg.keep[pvp_pkg::KEEP_T1_COUNT_LOW] ==
         $past(stateReg.keep[pvp_pkg::KEEP_T1_LATCH_LOW]));
  endproperty
  a_timer_one_load: assert property (p_timer_one_load) else $error("Timer reload lost.");

  c_write: cover property (@(posedge core_clk) disable iff (!reset_n) writeNow);
  c_read: cover property (@(posedge core_clk) disable iff (!reset_n) hostDataOe ##1 !hostDataOe);
  c_irq: cover property (@(posedge core_clk) disable iff (!reset_n) $rose(irqOe));
  c_handshake: cover property (@(posedge core_clk) disable iff (!reset_n) port_a_strobe_io);
  c_quiet: cover property (@(posedge core_clk) disable iff (!reset_n)
    writeNow && pins.bus.registerIndex == pvp_pkg::REG_PORT_A_QUIET);

endmodule // pvp_host_port

//--- verification/pvp_cpu_model.sv
`timescale 1ns/10ps
module pvp_cpu_model (
  // Clock.
  input  wire logic       core_clk,
  // Processor bus pins.
  output      logic       phi2,
  output      logic       select_high,
  output      logic       select_low_n,
  output      logic       readWrite,
  output      logic [3:0] register_index,
  output      logic [7:0] busData,
  // Device answer and what the processor took from it.
  input  wire logic [7:0] hostDataOut,
  input  wire logic       hostDataOe,
  output      logic       seenValid,
  output      logic [8:0] seenWord
);
  logic       driving = 1'b0;
  logic [7:0] wrData  = 8'h00;
  logic [7:0] idlePat = 8'h5a;

  // A released bus has no keeper, so it shows a moving pattern, never the last byte.
  always @(posedge core_clk) idlePat <= {idlePat[6:0], ~idlePat[7]};
  assign busData = driving ? wrData : idlePat;

  // Idle pins until the first cycle.
  initial begin
    {phi2, select_high, seenValid, register_index, seenWord} = '0;
    {select_low_n, readWrite} = 2'b11;
  end

  // One bus cycle; everything holds from phi2 rise until five cycles after its fall.
  task automatic access(input logic [1:0] sel, input logic rw, input logic [3:0] idx,
                        input logic [7:0] d);
    @(posedge core_clk);
    #1;
    {select_high, select_low_n, readWrite, register_index} = {sel, rw, idx};
    wrData = d;
    driving = ~rw;
    phi2 = 1'b1;
    repeat (6) @(posedge core_clk);
    seenWord = {hostDataOe, hostDataOut};
    #1;
    phi2 = 1'b0;
    seenValid = rw;
    @(posedge core_clk);
    #1;
    seenValid = 1'b0;
    repeat (4) @(posedge core_clk);
    #1;
    {select_high, select_low_n, readWrite, driving} = 4'b0110;
  endtask
endmodule // pvp_cpu_model

//--- verification/tb.sv
`timescale 1ns/10ps
module tb;
  logic        core_clk = 1'b0;
  logic        reset_n  = 1'b0;
  logic        strobeIn = 1'b1;
  logic        phi2, selectHigh, selectLowN, readWrite, hostDataOe, irqOut_n, irqOe;
  logic        strobeIo, strobeOe, seenValid;
  logic [3:0]  regIndex;
  logic [7:0]  busData, hostDataIn, hostDataOut, portAOut, portAOe, portBOut, portBOe;
  logic [7:0]  portAIn = 8'h00;
  logic [7:0]  portBIn = 8'h00;
  logic [7:0]  rnd     = 8'h19;
  logic [8:0]  seenWord;
  logic [17:0] notes[$];
  logic [17:0] note;
  int          fail_count = 0;
  int          checks_done = 0;
  int          strobeCount = 0;
  int          s0;

  // The device wins the bus whenever it drives; otherwise the processor's level shows.
  assign hostDataIn = hostDataOe ? hostDataOut : busData;
  always #50 core_clk = ~core_clk;

  pvp_host_port u_pvp_host_port (.core_clk(core_clk), .reset_n(reset_n), .phi2(phi2),
    .select_high(selectHigh), .select_low_n(selectLowN), .readWrite(readWrite),
    .register_index(regIndex), .hostDataIn(hostDataIn), .hostDataOut(hostDataOut),
    .hostDataOe(hostDataOe), .irqOut_n(irqOut_n), .irqOe(irqOe), .portAIn(portAIn),
    .portAOut(portAOut), .portAOe(portAOe), .portBIn(portBIn), .portBOut(portBOut),
    .portBOe(portBOe), .port_a_strobe_in(strobeIn), .port_a_strobe_io(strobeIo),
    .portAStrobeIoOe(strobeOe));
  pvp_cpu_model u_pvp_cpu_model (.core_clk(core_clk), .phi2(phi2), .select_high(selectHigh),
    .select_low_n(selectLowN), .readWrite(readWrite), .register_index(regIndex),
    .busData(busData), .hostDataOut(hostDataOut), .hostDataOe(hostDataOe),
    .seenValid(seenValid), .seenWord(seenWord));

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] seen);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] idx, input logic [7:0] d, input logic [1:0] sel = 2'b10);
    u_pvp_cpu_model.access(sel, 1'b0, idx, d);
  endtask

  // An unselected read only expects the bus left floating, so its data bits are masked.
  task automatic rd(input logic [3:0] idx, input logic [7:0] e, input logic [1:0] sel = 2'b10);
    notes.push_back((sel == 2'b10) ? {9'h1ff, 1'b1, e} : {9'h100, 9'h000});
    u_pvp_cpu_model.access(sel, 1'b1, idx, 8'h00);
  endtask

  task automatic final_report();
    if (fail_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Each byte the processor took is matched against the oldest expectation.
  always @(posedge core_clk) begin
    if (seenValid) begin
      note = notes.pop_front();
      chk("read", note[8:0], seenWord & note[17:9]);
    end
  end

  // Strobe pulses are counted so handshake activity per index can be judged.
  always @(posedge core_clk) if (strobeIo === 1'b1) strobeCount++;

  // Main sequence.
  initial begin
    repeat (12) @(posedge core_clk);
    #1 reset_n = 1'b1;
    chk("oe", 9'h000, {irqOe, portAOe});
    chk("bus oe", 9'h000, {hostDataOe, portBOe});
    for (int i = 2; i < 15; i++) if (i < 4 || i > 10) rd(i[3:0], (i == 14) ? 8'h80 : 8'h00);
    for (int i = 2; i < 13; i++) if (i < 4 || i > 10) begin
      rnd = lfsr(rnd);
      wr(i[3:0], rnd);
      rd(i[3:0], rnd);
    end
    wr(4'h2, 8'hf0);
    wr(4'h3, 8'h0f);
    chk("dir b", 9'h0f0, {1'b0, portBOe});
    chk("dir a", 9'h00f, {1'b0, portAOe});
    wr(4'hb, 8'h3c);
    wr(4'hb, 8'hc3, 2'b00);
    wr(4'hb, 8'hc3, 2'b11);
    rd(4'hb, 8'h00, 2'b00);
    rd(4'hb, 8'h3c);
    portBIn = 8'h3c;
    wr(4'h0, 8'ha5);
    rd(4'h0, 8'hac);
    chk("port b out", 9'h0a5, {1'b0, portBOut});
    portAIn = 8'h96;
    s0 = strobeCount;
    wr(4'h1, 8'h5a);
    chk("port a out", 9'h05a, {1'b0, portAOut});
    rd(4'h1, 8'h96);
    rd(4'hf, 8'h96);
    wr(4'hf, 8'h11);
    chk("quiet out", 9'h011, {1'b0, portAOut});
    chk("strobes", 9'h002, 9'(strobeCount - s0));
    wr(4'h4, 8'h12);
    wr(4'h5, 8'h34);
    rd(4'h4, 8'h12);
    rd(4'h5, 8'h34);
    rd(4'h6, 8'h12);
    rd(4'h7, 8'h34);
    wr(4'h8, 8'h56);
    wr(4'h9, 8'h78);
    rd(4'h8, 8'h56);
    rd(4'h9, 8'h78);
    wr(4'hc, 8'h00);
    wr(4'he, 8'h82);
    rd(4'he, 8'h82);
    strobeIn = 1'b0;
    repeat (8) @(posedge core_clk);
    #1 chk("irq on", 9'h002, {irqOe, irqOut_n});
    rd(4'hd, 8'h82);
    wr(4'hd, 8'h02);
    repeat (2) @(posedge core_clk);
    #1 chk("irq off", 9'h000, {irqOe, irqOut_n});
    strobeIn = 1'b1;
    wr(4'ha, 8'h9e);
    wr(4'hc, 8'h08);
    chk("strobe oe", 9'h001, {8'h00, strobeOe});
    @(posedge core_clk);
    #1 reset_n = 1'b0;
    repeat (3) @(posedge core_clk);
    #1 reset_n = 1'b1;
    chk("reset oe", 9'h000, {strobeOe, portBOe});
    rd(4'ha, 8'h9e);
    rd(4'h6, 8'h12);
    rd(4'h2, 8'h00);
    repeat (2) @(posedge core_clk);
    final_report();
  end

  // Watchdog on the whole run.
  initial begin
    repeat (60000) @(posedge core_clk);
    fail_count++;
    final_report();
  end
endmodule // tb
